// ===== logic/window_limit_params.svh
// constants for the channel window limit register slice
`ifndef WINDOW_LIMIT_PARAMS_SVH
`define WINDOW_LIMIT_PARAMS_SVH

// register byte addresses
`define OFS_HIGH_LIMIT_UPPER_CH1        8'h25
`define OFS_LOW_NIBBLE_AND_COUNT_CH1    8'h26
`define OFS_LOW_LIMIT_UPPER_CH1         8'h27
`define OFS_HIGH_NIBBLE_AND_MARGIN_CH2  8'h28
`define OFS_HIGH_LIMIT_UPPER_CH2        8'h29
`define OFS_LOW_NIBBLE_AND_COUNT_CH2    8'h2a

// reset values
`define RST_HIGH_LIMIT_UPPER_CH1        8'hff
`define RST_LOW_NIBBLE_AND_COUNT_CH1    8'h00
`define RST_LOW_LIMIT_UPPER_CH1         8'h00
`define RST_HIGH_NIBBLE_AND_MARGIN_CH2  8'hf0
`define RST_HIGH_LIMIT_UPPER_CH2        8'hff
`define RST_LOW_NIBBLE_AND_COUNT_CH2    8'h00

// field positions inside the split registers
`define NIBBLE_HI_MSB                   7
`define NIBBLE_HI_LSB                   4
`define NIBBLE_LO_MSB                   3
`define NIBBLE_LO_LSB                   0
`define MARGIN_SHIFT                    3

// channel numbers as they arrive with a conversion result
`define CH_ONE                          3'h1
`define CH_TWO                          3'h2

// value returned for an address outside this slice
`define UNMAPPED_READ                   8'h00

`endif

// ===== logic/window_limit_pkg.sv
// types shared by the channel window limit register slice
package window_limit_pkg;

	typedef struct packed {
		logic        valid;
		logic [2:0]  channel;
		logic [11:0] result;
	} conv_sample_s;

	typedef struct packed {
		logic [7:0] high_upper;
		logic [3:0] high_nibble;
		logic [7:0] low_upper;
		logic [3:0] low_nibble;
		logic [3:0] margin;
		logic [3:0] repeat_count;
		logic       region_select;
		logic       digital;
	} limit_set_s;

	typedef struct packed {
		logic       hit;
		logic [2:0] index;
	} reg_slot_s;

	typedef enum {S_IDLE, S_RX, S_ACK_OUT, S_TX, S_ACK_IN} link_phase_e;

	typedef enum {K_ADDR, K_POINTER, K_DATA} byte_kind_e;

endpackage

// ===== logic/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps

module pin_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             CLOCK,
	input  wire logic             RST,
	input  wire logic [WIDTH-1:0] PIN,
	output logic      [WIDTH-1:0] SYNCED
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_s;

	sync_s st;
	sync_s next_st;

	always_comb begin
		next_st        = st;
		next_st.first  = PIN;
		next_st.second = st.first;
	end

	// idle bus level is high, so reset to ones to avoid a false start
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign SYNCED = st.second;

endmodule

// ===== logic/window_channel.sv
// digital window comparator with consecutive-sample counter for one channel
`timescale 1ns/100ps

module window_channel (
	input  wire logic                       CLOCK,
	input  wire logic                       RST,
	input  wire logic                       SAMPLE_VALID,
	input  wire logic [11:0]                RESULT,
	input  wire window_limit_pkg::limit_set_s LIMITS,
	input  wire logic                       FLAG_CLEAR,
	output logic                            EVENT_FLAG
);

	typedef struct packed {
		logic [3:0] count;
		logic       alarm;
		logic       flag;
	} chan_s;

	chan_s       st;
	chan_s       next_st;
	logic [11:0] high_limit;
	logic [11:0] low_limit;
	logic [11:0] margin;
	logic [11:0] high_release;
	logic [12:0] low_sum;
	logic [11:0] low_release;
	logic        outside_plain;
	logic        outside_held;
	logic        meets;

	always_comb begin
		high_limit = {LIMITS.high_upper, LIMITS.high_nibble};
		low_limit  = {LIMITS.low_upper, LIMITS.low_nibble};
		margin     = {5'h00, LIMITS.margin, 3'h0};
		high_release = (high_limit > margin) ? high_limit - margin : 12'h000;
		low_sum      = {1'b0, low_limit} + {1'b0, margin};
		low_release  = low_sum[12] ? 12'hfff : low_sum[11:0];
		outside_plain = (RESULT < low_limit) || (RESULT > high_limit);
		// once in alarm the window shrinks by the margin so noise near a limit holds it
		outside_held  = (RESULT < low_release) || (RESULT > high_release);
		if (LIMITS.digital) begin
			meets = LIMITS.region_select ? ~RESULT[0] : RESULT[0];
		end else if (LIMITS.region_select) begin
			meets = (RESULT > low_limit) && (RESULT < high_limit);
		end else begin
			meets = st.alarm ? outside_held : outside_plain;
		end
	end

	always_comb begin
		next_st = st;
		if (FLAG_CLEAR) begin
			next_st.flag = 1'b0;
		end
		if (SAMPLE_VALID) begin
			if (!meets) begin
				next_st.count = 4'h0;
				next_st.alarm = 1'b0;
			end else if (st.count >= LIMITS.repeat_count) begin
				next_st.flag  = 1'b1;
				next_st.alarm = 1'b1;
			end else begin
				next_st.count = st.count + 4'h1;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign EVENT_FLAG = st.flag;

endmodule

// ===== logic/window_limit_regs.sv
// limit registers for channels one and two, their serial port and comparators
`timescale 1ns/100ps
`include "window_limit_params.svh"

module window_limit_regs #(
	parameter logic [6:0] DEVICE_ADDRESS = 7'h2a  // arbitrary bus address
) (
	input  wire logic                          CLOCK,
	input  wire logic                          RST,
	input  wire logic                          SCL,
	input  wire logic                          SDA_IN,
	output logic                               SDA_OUT,
	output logic                               SDA_OE,
	input  wire window_limit_pkg::conv_sample_s SAMPLE,
	input  wire logic [7:0]                    HIGH_NIBBLE_AND_MARGIN_ONE,
	input  wire logic [7:0]                    LOW_LIMIT_TOP_BYTE_TWO,
	input  wire logic [1:0]                    REGION_SELECT,
	input  wire logic [1:0]                    DIGITAL_MODE,
	input  wire logic [1:0]                    FLAG_CLEAR,
	output logic [1:0]                         EVENT_FLAG
);

	localparam int REG_COUNT = 6;

	typedef struct packed {
		window_limit_pkg::link_phase_e phase;
		window_limit_pkg::byte_kind_e  kind;
		logic [2:0]                    bit_idx;
		logic                          byte_done;
		logic [7:0]                    shifter;
		logic [7:0]                    pointer;
		logic                          reading;
		logic                          sda_low;
		logic                          scl_prev;
		logic                          sda_prev;
		logic [REG_COUNT-1:0][7:0]     regs;
	} port_s;

	localparam port_s RESET_STATE = '{
		phase:     window_limit_pkg::S_IDLE,
		kind:      window_limit_pkg::K_ADDR,
		bit_idx:   3'h0,
		byte_done: 1'b0,
		shifter:   8'h00,
		pointer:   8'h00,
		reading:   1'b0,
		sda_low:   1'b0,
		scl_prev:  1'b1,
		sda_prev:  1'b1,
		regs:      {`RST_LOW_NIBBLE_AND_COUNT_CH2,
		            `RST_HIGH_LIMIT_UPPER_CH2,
		            `RST_HIGH_NIBBLE_AND_MARGIN_CH2,
		            `RST_LOW_LIMIT_UPPER_CH1,
		            `RST_LOW_NIBBLE_AND_COUNT_CH1,
		            `RST_HIGH_LIMIT_UPPER_CH1}
	};

	port_s                        st;
	port_s                        next_st;
	logic [1:0]                   pins;
	logic                         scl;
	logic                         sda;
	logic                         scl_rise;
	logic                         scl_fall;
	logic                         start_seen;
	logic                         stop_seen;
	window_limit_pkg::reg_slot_s  slot;
	logic [7:0]                   read_value;
	window_limit_pkg::limit_set_s limits_one;
	window_limit_pkg::limit_set_s limits_two;

	// one decode serves both the read path and the write path
	function automatic window_limit_pkg::reg_slot_s map_slot(input logic [7:0] addr);
		window_limit_pkg::reg_slot_s s;
		s.hit   = 1'b1;
		s.index = 3'h0;
		case (addr)
			`OFS_HIGH_LIMIT_UPPER_CH1: begin
				s.index = 3'h0;
			end
			`OFS_LOW_NIBBLE_AND_COUNT_CH1: begin
				s.index = 3'h1;
			end
			`OFS_LOW_LIMIT_UPPER_CH1: begin
				s.index = 3'h2;
			end
			`OFS_HIGH_NIBBLE_AND_MARGIN_CH2: begin
				s.index = 3'h3;
			end
			`OFS_HIGH_LIMIT_UPPER_CH2: begin
				s.index = 3'h4;
			end
			`OFS_LOW_NIBBLE_AND_COUNT_CH2: begin
				s.index = 3'h5;
			end
			default: begin
				s.hit = 1'b0;
			end
		endcase
		return s;
	endfunction

	pin_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.CLOCK  (CLOCK),
		.RST    (RST),
		.PIN    ({SCL, SDA_IN}),
		.SYNCED (pins)
	);

	assign scl        = pins[1];
	assign sda        = pins[0];
	assign scl_rise   = scl & ~st.scl_prev;
	assign scl_fall   = ~scl & st.scl_prev;
	assign start_seen = scl & st.scl_prev & st.sda_prev & ~sda;
	assign stop_seen  = scl & st.scl_prev & ~st.sda_prev & sda;
	assign slot       = map_slot(st.pointer);
	assign read_value = slot.hit ? st.regs[slot.index] : `UNMAPPED_READ;

	always_comb begin
		next_st          = st;
		next_st.scl_prev = scl;
		next_st.sda_prev = sda;
		if (start_seen) begin
			// a repeated start keeps the pointer so a read can follow a pointer write
			next_st.phase     = window_limit_pkg::S_RX;
			next_st.kind      = window_limit_pkg::K_ADDR;
			next_st.bit_idx   = 3'h0;
			next_st.byte_done = 1'b0;
			next_st.sda_low   = 1'b0;
		end else if (stop_seen) begin
			next_st.phase   = window_limit_pkg::S_IDLE;
			next_st.sda_low = 1'b0;
		end else begin
			case (st.phase)
				window_limit_pkg::S_RX: begin
					if (scl_rise) begin
						next_st.shifter = {st.shifter[6:0], sda};
						next_st.bit_idx = st.bit_idx + 3'h1;
						if (st.bit_idx == 3'h7) begin
							next_st.byte_done = 1'b1;
						end
					end else if (scl_fall && st.byte_done) begin
						next_st.byte_done = 1'b0;
						next_st.phase     = window_limit_pkg::S_ACK_OUT;
						next_st.sda_low   = 1'b1;
						case (st.kind)
							window_limit_pkg::K_ADDR: begin
								next_st.reading = st.shifter[0];
								if (st.shifter[7:1] != DEVICE_ADDRESS) begin
									next_st.phase   = window_limit_pkg::S_IDLE;
									next_st.sda_low = 1'b0;
								end
							end
							window_limit_pkg::K_POINTER: begin
								next_st.pointer = st.shifter;
							end
							window_limit_pkg::K_DATA: begin
								if (slot.hit) begin
									next_st.regs[slot.index] = st.shifter;
								end
								next_st.pointer = st.pointer + 8'h01;
							end
							default: begin
								next_st.phase   = window_limit_pkg::S_IDLE;
								next_st.sda_low = 1'b0;
							end
						endcase
					end
				end
				window_limit_pkg::S_ACK_OUT: begin
					if (scl_fall) begin
						next_st.bit_idx = 3'h0;
						if (st.reading) begin
							next_st.phase   = window_limit_pkg::S_TX;
							next_st.shifter = read_value;
							next_st.sda_low = ~read_value[7];
							next_st.pointer = st.pointer + 8'h01;
						end else begin
							next_st.phase   = window_limit_pkg::S_RX;
							next_st.sda_low = 1'b0;
							next_st.kind    = (st.kind == window_limit_pkg::K_ADDR) ?
								window_limit_pkg::K_POINTER : window_limit_pkg::K_DATA;
						end
					end
				end
				window_limit_pkg::S_TX: begin
					if (scl_fall) begin
						next_st.bit_idx = st.bit_idx + 3'h1;
						if (st.bit_idx == 3'h7) begin
							next_st.phase     = window_limit_pkg::S_ACK_IN;
							next_st.sda_low   = 1'b0;
							next_st.byte_done = 1'b0;
						end else begin
							next_st.shifter = {st.shifter[6:0], 1'b0};
							next_st.sda_low = ~st.shifter[6];
						end
					end
				end
				window_limit_pkg::S_ACK_IN: begin
					if (scl_rise) begin
						next_st.byte_done = ~sda;
					end else if (scl_fall) begin
						next_st.bit_idx = 3'h0;
						if (st.byte_done) begin
							next_st.phase   = window_limit_pkg::S_TX;
							next_st.shifter = read_value;
							next_st.sda_low = ~read_value[7];
							next_st.pointer = st.pointer + 8'h01;
						end else begin
							// host said no more: release the line and wait for stop
							next_st.phase = window_limit_pkg::S_IDLE;
						end
						next_st.byte_done = 1'b0;
					end
				end
				default: begin
					next_st.sda_low = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	// open drain: the pad only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE  = st.sda_low;

	always_comb begin
		limits_one.high_upper    = st.regs[0];
		limits_one.high_nibble   = HIGH_NIBBLE_AND_MARGIN_ONE[`NIBBLE_HI_MSB:`NIBBLE_HI_LSB];
		limits_one.margin        = HIGH_NIBBLE_AND_MARGIN_ONE[`NIBBLE_LO_MSB:`NIBBLE_LO_LSB];
		limits_one.low_nibble    = st.regs[1][`NIBBLE_HI_MSB:`NIBBLE_HI_LSB];
		limits_one.repeat_count  = st.regs[1][`NIBBLE_LO_MSB:`NIBBLE_LO_LSB];
		limits_one.low_upper     = st.regs[2];
		limits_one.region_select = REGION_SELECT[0];
		limits_one.digital       = DIGITAL_MODE[0];
		limits_two.high_nibble   = st.regs[3][`NIBBLE_HI_MSB:`NIBBLE_HI_LSB];
		limits_two.margin        = st.regs[3][`NIBBLE_LO_MSB:`NIBBLE_LO_LSB];
		limits_two.high_upper    = st.regs[4];
		limits_two.low_nibble    = st.regs[5][`NIBBLE_HI_MSB:`NIBBLE_HI_LSB];
		limits_two.repeat_count  = st.regs[5][`NIBBLE_LO_MSB:`NIBBLE_LO_LSB];
		limits_two.low_upper     = LOW_LIMIT_TOP_BYTE_TWO;
		limits_two.region_select = REGION_SELECT[1];
		limits_two.digital       = DIGITAL_MODE[1];
	end

	window_channel u_channel_one (
		.CLOCK        (CLOCK),
		.RST          (RST),
		.SAMPLE_VALID (SAMPLE.valid && SAMPLE.channel == `CH_ONE),
		.RESULT       (SAMPLE.result),
		.LIMITS       (limits_one),
		.FLAG_CLEAR   (FLAG_CLEAR[0]),
		.EVENT_FLAG   (EVENT_FLAG[0])
	);

	window_channel u_channel_two (
		.CLOCK        (CLOCK),
		.RST          (RST),
		.SAMPLE_VALID (SAMPLE.valid && SAMPLE.channel == `CH_TWO),
		.RESULT       (SAMPLE.result),
		.LIMITS       (limits_two),
		.FLAG_CLEAR   (FLAG_CLEAR[1]),
		.EVENT_FLAG   (EVENT_FLAG[1])
	);

endmodule

// ===== testbench/window_limit_regs_props.sv
// concurrent checks on the limit register slice ports
`timescale 1ns/100ps

module window_limit_regs_props (
	input  wire logic                           CLOCK,
	input  wire logic                           RST,
	input  wire logic                           SCL,
	input  wire logic                           SDA_OE,
	input  wire window_limit_pkg::conv_sample_s SAMPLE,
	input  wire logic [1:0]                     REGION_SELECT,
	input  wire logic [1:0]                     DIGITAL_MODE,
	input  wire logic [1:0]                     FLAG_CLEAR,
	input  wire logic [1:0]                     EVENT_FLAG
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence s_digital_zero;
		SAMPLE.valid && SAMPLE.channel == 3'h1 && DIGITAL_MODE[0] && !REGION_SELECT[0]
			&& !SAMPLE.result[0] && !EVENT_FLAG[0];
	endsequence
	sequence s_ack_hold;
		SDA_OE [*8];
	endsequence

	chk_quiet_one: assert property ((!SAMPLE.valid || SAMPLE.channel != 3'h1)
		&& !EVENT_FLAG[0] |=> !EVENT_FLAG[0]) else $error("flag one rose without sample");
	chk_quiet_two: assert property ((!SAMPLE.valid || SAMPLE.channel != 3'h2)
		&& !EVENT_FLAG[1] |=> !EVENT_FLAG[1]) else $error("flag two rose without sample");
	chk_hold_one: assert property (EVENT_FLAG[0] && !FLAG_CLEAR[0] |=> EVENT_FLAG[0])
		else $error("flag one dropped without clear");
	chk_hold_two: assert property (EVENT_FLAG[1] && !FLAG_CLEAR[1] |=> EVENT_FLAG[1])
		else $error("flag two dropped without clear");
	chk_clear_one: assert property (FLAG_CLEAR[0] && !SAMPLE.valid |=> !EVENT_FLAG[0])
		else $error("flag one not cleared");
	chk_digital_low: assert property (s_digital_zero |=> !EVENT_FLAG[0])
		else $error("digital zero raised flag");
	chk_ack_edge: assert property ($changed(SDA_OE) |-> !SCL && !$past(SCL) && !$past(SCL, 2))
		else $error("data line moved while clock high");
	chk_ack_stands: assert property ($rose(SDA_OE) |=> s_ack_hold)
		else $error("data line pull too short");
endmodule

bind window_limit_regs window_limit_regs_props u_props (
	.CLOCK(CLOCK), .RST(RST), .SCL(SCL), .SDA_OE(SDA_OE), .SAMPLE(SAMPLE),
	.REGION_SELECT(REGION_SELECT), .DIGITAL_MODE(DIGITAL_MODE),
	.FLAG_CLEAR(FLAG_CLEAR), .EVENT_FLAG(EVENT_FLAG)
);

// ===== testbench/i2c_host_model.sv
// serial host model that configures the limit registers
`timescale 1ns/100ps

module i2c_host_model (
	input  wire logic CLOCK,
	input  wire logic SDA_OE,
	input  wire logic SDA_OUT,
	output logic      SCL,
	output logic      SDA
);
	logic drive;

	// pull-up wire: low whenever either party pulls
	assign SDA = drive & ~(SDA_OE & ~SDA_OUT);

	initial begin
		SCL = 1'b1;
		drive = 1'b1;
	end

	task automatic half;
		repeat (8) @(posedge CLOCK);
	endtask

	// serves as repeated start as well
	task automatic start;
		half;
		drive <= 1'b1;
		half;
		SCL <= 1'b1;
		half;
		drive <= 1'b0;
		half;
		SCL <= 1'b0;
	endtask

	task automatic stop;
		half;
		drive <= 1'b0;
		half;
		SCL <= 1'b1;
		half;
		drive <= 1'b1;
		half;
	endtask

	// data moves mid low phase so it never races the clock fall
	task automatic bit_io(input logic b, output logic got);
		repeat (4) @(posedge CLOCK);
		drive <= b;
		repeat (4) @(posedge CLOCK);
		SCL <= 1'b1;
		repeat (7) @(posedge CLOCK);
		#1 got = SDA;
		@(posedge CLOCK) SCL <= 1'b0;
	endtask

	task automatic put(input logic [7:0] d, output logic nack);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(d[i], g);
		bit_io(1'b1, nack);
	endtask

	task automatic get(input logic last, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, g);
			d[i] = g;
		end
		bit_io(last, g);
	endtask
endmodule

// ===== testbench/window_limit_regs_tb_top.sv
// self-checking bench for the channel window limit register slice
`timescale 1ns/100ps

module window_limit_regs_tb_top;
	localparam logic [6:0] ADDR = 7'h2a;
	logic                           CLOCK = 1'b0;
	logic                           RST = 1'b1;
	logic                           scl;
	logic                           sda;
	logic                           sda_out;
	logic                           sda_oe;
	window_limit_pkg::conv_sample_s sample;
	logic [7:0]                     nib1;
	logic [7:0]                     low2;
	logic [1:0]                     rsel;
	logic [1:0]                     dmode;
	logic [1:0]                     fclr;
	logic [1:0]                     flag;
	int                             fail_count = 0;
	int                             samples_checked = 0;
	int                             cycles = 0;
	logic                           nacks = 1'b0;
	logic                           k;
	logic [7:0]                     d;
	logic [7:0] rst_val [6] = '{8'hff, 8'h00, 8'h00, 8'hf0, 8'hff, 8'h00};
	logic [7:0] pat [6] = '{8'hc0, 8'h30, 8'h40, 8'h52, 8'h80, 8'h02};

	always #10 CLOCK = ~CLOCK;

	window_limit_regs #(.DEVICE_ADDRESS(ADDR)) u_dut (
		.CLOCK(CLOCK), .RST(RST), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .SAMPLE(sample), .HIGH_NIBBLE_AND_MARGIN_ONE(nib1),
		.LOW_LIMIT_TOP_BYTE_TWO(low2), .REGION_SELECT(rsel), .DIGITAL_MODE(dmode),
		.FLAG_CLEAR(fclr), .EVENT_FLAG(flag)
	);

	i2c_host_model u_host (
		.CLOCK(CLOCK), .SDA_OE(sda_oe), .SDA_OUT(sda_out), .SCL(scl), .SDA(sda)
	);

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	task automatic open(input logic [7:0] ptr);
		logic k1;
		logic k2;
		u_host.start;
		u_host.put({ADDR, 1'b0}, k1);
		u_host.put(ptr, k2);
		nacks |= k1 | k2;
	endtask

	task automatic rd_open;
		logic k1;
		u_host.start;
		u_host.put({ADDR, 1'b1}, k1);
		nacks |= k1;
	endtask

	task automatic smp(input logic [2:0] ch, input logic [11:0] r);
		@(posedge CLOCK) sample <= {1'b1, ch, r};
		@(posedge CLOCK) sample.valid <= 1'b0;
		#1;
	endtask

	task automatic clr(input logic [1:0] m);
		@(posedge CLOCK) fclr <= m;
		@(posedge CLOCK) fclr <= 2'b00;
		#1;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// a full run needs under ten thousand cycles
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done;
		end
	end

	initial begin
		sample = '0;
		nib1 = 8'h00;
		low2 = 8'h10;
		rsel = 2'b00;
		dmode = 2'b00;
		fclr = 2'b00;
		repeat (3) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (3) @(posedge CLOCK);
		open(8'h25);
		rd_open;
		for (int i = 0; i < 7; i++) begin
			u_host.get(i == 6, d);
			cmp8(d, i < 6 ? rst_val[i] : 8'h00);
		end
		u_host.stop;
		$display("test reset values done");
		open(8'h25);
		for (int i = 0; i < 6; i++) begin
			u_host.put(pat[i], k);
			nacks |= k;
		end
		u_host.stop;
		open(8'h25);
		rd_open;
		for (int i = 0; i < 6; i++) begin
			u_host.get(i == 5, d);
			cmp8(d, pat[i]);
		end
		u_host.stop;
		cmp1(nacks, 1'b0);
		u_host.start;
		u_host.put({ADDR + 7'h01, 1'b0}, k);
		u_host.stop;
		cmp1(k, 1'b1);
		$display("test access done");
		// channel two: high 0x805, margin 16, three samples needed
		smp(3'h2, 12'h806);
		smp(3'h2, 12'h806);
		smp(3'h2, 12'h805);
		smp(3'h2, 12'h806);
		smp(3'h2, 12'h806);
		cmp1(flag[1], 1'b0);
		smp(3'h2, 12'h806);
		cmp1(flag[1], 1'b1);
		cmp1(flag[0], 1'b0);
		clr(2'b10);
		smp(3'h2, 12'h7fc);
		cmp1(flag[1], 1'b1);
		clr(2'b10);
		smp(3'h2, 12'h7f0);
		smp(3'h2, 12'h7fc);
		smp(3'h2, 12'h806);
		cmp1(flag[1], 1'b0);
		$display("test channel two done");
		smp(3'h1, 12'h403);
		cmp1(flag[0], 1'b0);
		smp(3'h1, 12'h402);
		cmp1(flag[0], 1'b1);
		clr(2'b01);
		cmp1(flag[0], 1'b0);
		@(posedge CLOCK) nib1 <= 8'h80;
		smp(3'h1, 12'hc08);
		cmp1(flag[0], 1'b0);
		smp(3'h1, 12'hc09);
		cmp1(flag[0], 1'b1);
		clr(2'b01);
		@(posedge CLOCK) dmode <= 2'b01;
		smp(3'h1, 12'h000);
		cmp1(flag[0], 1'b0);
		smp(3'h1, 12'h001);
		cmp1(flag[0], 1'b1);
		clr(2'b01);
		@(posedge CLOCK) rsel <= 2'b01;
		smp(3'h1, 12'h001);
		cmp1(flag[0], 1'b0);
		smp(3'h1, 12'h000);
		cmp1(flag[0], 1'b1);
		// analog inside-window region on channel one, no hysteresis there
		clr(2'b01);
		@(posedge CLOCK) dmode <= 2'b10;
		smp(3'h1, 12'h403);
		cmp1(flag[0], 1'b0);
		smp(3'h1, 12'h404);
		cmp1(flag[0], 1'b1);
		// digital input on channel two with the inverted region, n+1 = 3
		@(posedge CLOCK) rsel <= 2'b11;
		smp(3'h2, 12'h001);
		smp(3'h2, 12'h000);
		smp(3'h2, 12'h000);
		cmp1(flag[1], 1'b0);
		smp(3'h2, 12'h000);
		cmp1(flag[1], 1'b1);
		$display("test channel one done");
		@(posedge CLOCK) RST <= 1'b1;
		repeat (3) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (3) @(posedge CLOCK);
		cmp8({6'h00, flag}, 8'h00);
		open(8'h28);
		rd_open;
		u_host.get(1'b0, d);
		cmp8(d, 8'hf0);
		u_host.get(1'b1, d);
		cmp8(d, 8'hff);
		u_host.stop;
		$display("test second reset done");
		test_done;
	end
endmodule
